// File: dmab_axi_model.sv
// axi partner: answers read bursts beat by beat and takes write bursts
// assumes the engine holds each request until ready and runs one burst per side
module dmab_axi_model (
  // engine requests
  input  wire          clock_i, srst_i, arvalid_o, rready_o, awvalid_o, wvalid_o,
  input  wire          wlast_o, bready_o, drop_last_i, slow_i,
  input  wire [3:0]    arlen_o,
  input  wire [4:0]    err_beat_i,
  input  wire [127:0]  wdata_o,
  input  wire [15:0]   wstrb_o,
  // answers
  output logic         arready_i, rvalid_i, rlast_i, awready_i, wready_i, bvalid_i,
  output logic [127:0] rdata_i,
  output logic [1:0]   rresp_i
);
  timeunit 1ns;
  timeprecision 1ps;
  int arn, rbeats, awn, wbeats, wnz, bn;  // traffic counts, cleared by reset
  int len;                                // index of the last beat of the current read burst
  // counts restart with every reset
  always @(posedge clock_i) if (srst_i) begin
    arn = 0; rbeats = 0; awn = 0; wbeats = 0; wnz = 0; bn = 0;
  end
  // read side: optional slow address accept, fault on one chosen beat
  initial begin
    {arready_i, rvalid_i, rlast_i, rresp_i} = '0;
    rdata_i = 128'h0;
    forever begin
      @(posedge clock_i);
      if (arvalid_o && !srst_i) begin
        if (slow_i) repeat (3) @(posedge clock_i);
        arready_i <= 1'b1;
        len = arlen_o;
        arn++;
        @(posedge clock_i);
        arready_i <= 1'b0;
        for (int n = 0; n <= len; n++) begin
          rvalid_i <= 1'b1;
          rdata_i <= {4{32'hA5A5_0000 + 32'(n)}};
          rresp_i <= (n == err_beat_i) ? 2'b10 : 2'b00;
          rlast_i <= (n == len) && !drop_last_i;
          do @(posedge clock_i); while (!rready_o && !srst_i);
          if (srst_i) break;
          rbeats++;
          // a slow partner leaves gaps with scrambled data between beats
          if (slow_i && n < len) begin
            rvalid_i <= 1'b0;
            rdata_i <= ~rdata_i;
            @(posedge clock_i);
          end
        end
        rvalid_i <= 1'b0;
        rlast_i <= 1'b0;
        rresp_i <= 2'b00;
        rdata_i <= ~rdata_i;
      end
    end
  end
  // write side: address, beats until last, then one response
  initial begin
    {awready_i, wready_i, bvalid_i} = '0;
    forever begin
      @(posedge clock_i);
      if (awvalid_o && !srst_i) begin
        awready_i <= 1'b1;
        awn++;
        @(posedge clock_i);
        awready_i <= 1'b0;
        wready_i <= 1'b1;
        do begin
          @(posedge clock_i);
          if (wvalid_o) wbeats++;
          if (wvalid_o && (wstrb_o != 16'h0000 || wdata_o != 128'h0)) wnz++;
        end while (!(wvalid_o && wlast_o) && !srst_i);
        wready_i <= 1'b0;
        bvalid_i <= !srst_i;
        do @(posedge clock_i); while (!bready_o && !srst_i);
        bvalid_i <= 1'b0;
        bn++;
      end
    end
  end
endmodule // dmab_axi_model

// File: dmab_fifo.v
// flip-flop buffer of 16 entries of 128 bits holding read beats until written out
// assumes the caller never pushes when full nor pops when empty
module dmab_fifo (
  // clock and reset
  input  wire         clock_i,
  input  wire         srst_i,
  // fill and drain
  input  wire         push_i,
  input  wire [127:0] data_i,
  input  wire         pop_i,
  output wire [127:0] head_o,
  output wire [4:0]   count_o
);
  reg [127:0] mem [0:15];   // storage
  reg [3:0]   wr_ptr;       // next write slot
  reg [3:0]   rd_ptr;       // head slot
  reg [4:0]   count;        // entries held

  assign head_o  = mem[rd_ptr];
  assign count_o = count;

  // ==========================================================
  // pointer and storage update
  always @(posedge clock_i) begin
    if (srst_i) begin
      wr_ptr <= 4'h0;
      rd_ptr <= 4'h0;
      count  <= 5'h00;
    end else begin
      if (push_i) begin
        mem[wr_ptr] <= data_i;
        wr_ptr      <= wr_ptr + 4'h1;
      end
      if (pop_i)
        rd_ptr <= rd_ptr + 4'h1;
      count <= count + {4'h0, push_i} - {4'h0, pop_i};
    end
  end
endmodule // dmab_fifo

// File: dmab_monitor.sv
// checker of handshake, fault and reset behaviour at the burst engine ports
// assumes one clock and a synchronous active-high reset
module dmab_monitor (
  // clock, reset and apb
  input wire         clock_i, srst_i, psel_i, penable_i, pready_o, pslverr_o,
  // axi handshakes
  input wire         arvalid_o, arready_i, rvalid_i, rready_o, rlast_i,
  input wire         awvalid_o, awready_i, wvalid_o, wready_i, wlast_o, irq_o,
  // axi payload
  input wire [39:0]  araddr_o, awaddr_o,
  input wire [3:0]   arlen_o, awlen_o,
  input wire [1:0]   rresp_i,
  input wire [127:0] wdata_o,
  input wire [15:0]  wstrb_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // properties, all in the one clock domain
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  apb_ack_a: assert property ($rose(penable_i) && psel_i |=> pready_o ##1 !pready_o)
    else $error("apb answer not after one wait state");
  slverr_ack_a: assert property (pslverr_o |-> pready_o)
    else $error("slave error without ready");
  ar_hold_a: assert property (arvalid_o && !arready_i |=>
    arvalid_o && $stable(araddr_o) && $stable(arlen_o)) else $error("read request changed");
  aw_hold_a: assert property (awvalid_o && !awready_i |=>
    awvalid_o && $stable(awaddr_o) && $stable(awlen_o)) else $error("write request changed");
  rd_excl_a: assert property (arvalid_o |-> !rready_o && !awvalid_o)
    else $error("read request overlaps other traffic");
  zero_beat_a: assert property (wvalid_o && wstrb_o == 16'h0000 |-> wdata_o == 128'h0)
    else $error("zero strobe beat carries data");
  w_gap_a: assert property (wvalid_o && wready_i && wlast_o |=> !wvalid_o)
    else $error("write data without new address");
  irq_err_a: assert property (rvalid_i && rready_o && rresp_i[1] |-> ##[1:6] irq_o)
    else $error("no interrupt after read fault");
  rest_taken_a: assert property (rvalid_i && rready_o && rresp_i[1] && !rlast_i
    |-> ##[1:40] rvalid_i && rready_o) else $error("beats after fault refused");
  reset_quiet_a: assert property ($past(srst_i) |-> !irq_o && !arvalid_o && !awvalid_o)
    else $error("outputs active after reset");
  // main scenarios reached
  cover property (arvalid_o && arready_i && arlen_o == 4'hf);
  cover property (wvalid_o && wready_i && wlast_o && wstrb_o == 16'h0000);
  cover property ($rose(irq_o));
endmodule // dmab_monitor

bind dmab_top dmab_monitor u_mon (.*);

// File: dmab_regs.vh
// register offsets, field positions, reset values and limits of the burst engine
// assumes an apb byte address of 8 bits and 32-bit data
`ifndef DMAB_REGS_VH
`define DMAB_REGS_VH
// ==========================================================
// register byte offsets
`define DMAB_OFF_CS        8'h00
`define DMAB_OFF_SRC       8'h04
`define DMAB_OFF_DST       8'h08
`define DMAB_OFF_LEN       8'h0C
`define DMAB_OFF_STRIDE    8'h10
`define DMAB_OFF_ROWS      8'h14
`define DMAB_OFF_NEXT      8'h18
`define DMAB_OFF_DEBUG     8'h1C
`define DMAB_OFF_HI        8'h20
// ==========================================================
// control/status field positions
`define DMAB_CS_ACTIVE     0
`define DMAB_CS_INTR       1
`define DMAB_CS_ABORT      2
`define DMAB_CS_ERROR      3
`define DMAB_CS_ZFILL      4
`define DMAB_CS_DISCARD    5
`define DMAB_CS_NARROW     6
`define DMAB_CS_NOPAIR     7
`define DMAB_CS_PACE       8
`define DMAB_CS_TWODIM     9
`define DMAB_CS_BLEN_LO    12
`define DMAB_CS_BLEN_HI    15
`define DMAB_CS_BUSY       16
// debug fault bits
`define DMAB_DBG_RDLAST    0
`define DMAB_DBG_FIFO      1
`define DMAB_DBG_RDRESP    2
// ==========================================================
// reset values and limits
`define DMAB_RST_WORD      32'h0000_0000
`define DMAB_MAX_BURST     5'h10
`define DMAB_CAP_WIDE_LITE 5'h01
`define DMAB_CAP_WIDE_FULL 5'h02
`define DMAB_CAP_WIDE_EXT  5'h09
`define DMAB_CAP_NAR_LITE  5'h04
`define DMAB_CAP_NAR_FULL  5'h08
`define DMAB_CAP_NAR_EXT   5'h10
`define DMAB_LITE_LEN_MASK 32'h0000_FFFF
`endif

// File: dmab_top.v
// burst generation and error capture of one dma channel, apb registers, axi master
// assumes a single clock; pacing and fifo fault come from outside and are synchronised
//
// Function
// - bursts never exceed sixteen beats
// - narrow peripheral reads capped at buffer room
// - discard mode reads full programmed burst, drops data
// - channels 0 and 15 add eight-word fifo
// - oversize read burst stalls read channel
// - zero fill writes zero data, zero strobes
// - wide writes paired into two-beat bursts
// - read response fault sticky, write-one clears
// - read fault clears active, raises interrupt
// - remaining read beats still accepted after fault
// - channels 0 and 15 latch external fifo fault, write-one clears
// - missing last flag sets fault bit
// - summary error is or of faults
// - lite holds one wide beat only
// - lite absorbs four narrow beats
// - lite ignores two-dim and ignore modes
// - lite length register sixteen bits wide
// - fast variant thirty-five-bit addresses, write bursts
// - fast variant drives address without paging
// - fast variant channel eleven reaches full address space
// - pacing sampled high before each read
`include "dmab_regs.vh"
module dmab_top #(
  parameter VARIANT = 0,  // 0 full, 1 lite, 2 fast
  parameter CHANNEL = 0   // channel number
) (
  // clock and reset
  input  wire         clock_i,
  input  wire         srst_i,
  // apb slave
  input  wire         psel_i,
  input  wire         penable_i,
  input  wire         pwrite_i,
  input  wire [7:0]   paddr_i,
  input  wire [31:0]  pwdata_i,
  output reg  [31:0]  prdata_o,
  output reg          pready_o,
  output reg          pslverr_o,
  // axi read address and data
  output reg          arvalid_o,
  input  wire         arready_i,
  output reg  [39:0]  araddr_o,
  output reg  [3:0]   arlen_o,
  output reg  [2:0]   arsize_o,
  input  wire         rvalid_i,
  output reg          rready_o,
  input  wire [127:0] rdata_i,
  input  wire [1:0]   rresp_i,
  input  wire         rlast_i,
  // axi write address, data and response
  output reg          awvalid_o,
  input  wire         awready_i,
  output reg  [39:0]  awaddr_o,
  output reg  [3:0]   awlen_o,
  output reg  [2:0]   awsize_o,
  output reg          wvalid_o,
  input  wire         wready_i,
  output reg  [127:0] wdata_o,
  output reg  [15:0]  wstrb_o,
  output reg          wlast_o,
  input  wire         bvalid_i,
  output reg          bready_o,
  // pacing, external fifo fault, interrupt
  input  wire         pacing_request_i,
  input  wire         fifo_fault_i,
  output reg          irq_o
);
  localparam IS_LITE = (VARIANT == 1);
  localparam IS_FAST = (VARIANT == 2);
  localparam HAS_EXT = (CHANNEL == 0) || (CHANNEL == 15);
  localparam RD_IDLE = 2'd0, RD_ADDR = 2'd1, RD_DATA = 2'd2;
  localparam WR_IDLE = 2'd0, WR_ADDR = 2'd1, WR_DATA = 2'd2, WR_RESP = 2'd3;

  // ==========================================================
  // registers
  reg [31:0] cs;            // control bits
  reg [31:0] src_lo;        // source address low word
  reg [31:0] dst_lo;        // destination address low word
  reg [31:0] len;           // bytes left to move
  reg [31:0] source_row_step;
  reg [31:0] row_count;
  reg [31:0] next_descriptor_pointer;
  reg [15:0] hi;            // source high [7:0], destination high [15:8]
  reg [2:0]  dbg;           // sticky faults
  reg [1:0]  pace_s;        // pacing synchroniser
  reg [1:0]  ffault_s;      // fifo fault synchroniser
  reg [1:0]  rd_state;
  reg [1:0]  wr_state;
  reg [3:0]  rbeat;         // beat index in current read burst
  reg [3:0]  wbeat;         // beat index in current write burst
  wire       active    = cs[`DMAB_CS_ACTIVE];
  wire       zero_source_fill_mode    = cs[`DMAB_CS_ZFILL];
  wire       discard_destination_mode = cs[`DMAB_CS_DISCARD];
  wire       narrow    = cs[`DMAB_CS_NARROW];
  wire [4:0] blen      = {1'b0, cs[`DMAB_CS_BLEN_HI:`DMAB_CS_BLEN_LO]} + 5'h01;
  wire [4:0] bbytes    = narrow ? 5'h04 : 5'h10;
  wire [4:0] fcount;
  wire [127:0] fhead;

  // ==========================================================
  // buffer room in beats for this variant and width
  reg [4:0] cap;
  always @* begin
    if (HAS_EXT)
      cap = narrow ? `DMAB_CAP_NAR_EXT : `DMAB_CAP_WIDE_EXT;
    else if (IS_LITE)
      cap = narrow ? `DMAB_CAP_NAR_LITE : `DMAB_CAP_WIDE_LITE;
    else
      cap = narrow ? `DMAB_CAP_NAR_FULL : `DMAB_CAP_WIDE_FULL;
  end

  // ==========================================================
  // beats left and length of the next burst
  wire [31:0] beats_left = narrow ? {2'b00, len[31:2]} : {4'h0, len[31:4]};
  reg  [4:0]  next_blen;
  always @* begin
    next_blen = blen;
    if (narrow && !discard_destination_mode && blen > cap)
      next_blen = cap;
    if (beats_left < {27'h0, next_blen})
      next_blen = beats_left[4:0];
    if (next_blen > `DMAB_MAX_BURST)
      next_blen = `DMAB_MAX_BURST;
  end

  // ==========================================================
  // addresses: fast variant drives full width on channel 11 and 35 bits unpaged on others; other variants page the low word
  function [39:0] eff_addr;
    input [7:0]  h;
    input [31:0] lo;
    begin
      if (IS_FAST)
        eff_addr = (CHANNEL == 11) ? {h, lo} : {5'h00, h[2:0], lo};
      else
        eff_addr = {5'h00, h[4:0], lo[29:0]};
    end
  endfunction

  // ==========================================================
  // synchronisers for outside levels
  always @(posedge clock_i) begin
    if (srst_i) begin
      pace_s   <= 2'b00;
      ffault_s <= 2'b00;
    end else begin
      pace_s   <= {pace_s[0], pacing_request_i};
      ffault_s <= {ffault_s[0], fifo_fault_i};
    end
  end

  // ==========================================================
  // handshakes and fault events
  wire r_hs     = rvalid_i && rready_o;
  wire rd_err   = r_hs && rresp_i[1];
  wire last_err = r_hs && ((rbeat == arlen_o) != rlast_i);
  wire w_hs     = wvalid_o && wready_i;
  wire keep     = r_hs && !discard_destination_mode;
  wire pop      = (wr_state == WR_IDLE) ? 1'b0 :
                  ((wr_state == WR_ADDR && awready_i) || (w_hs && !wlast_o))
                  && !zero_source_fill_mode;
  wire apb_acc  = psel_i && penable_i && pready_o;
  wire apb_wr   = apb_acc && pwrite_i;
  wire done     = active && len == 32'h0 && rd_state == RD_IDLE
                  && wr_state == WR_IDLE && fcount == 5'h00;

  // ==========================================================
  // read buffer
  dmab_fifo u_fifo (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .push_i  (keep),
    .data_i  (rdata_i),
    .pop_i   (pop),
    .head_o  (fhead),
    .count_o (fcount)
  );

  // ==========================================================
  // read state machine
  wire [4:0] free_next = cap - (fcount + {4'h0, keep} - {4'h0, pop});
  always @(posedge clock_i) begin
    if (srst_i) begin
      rd_state  <= RD_IDLE;
      arvalid_o <= 1'b0;
      araddr_o  <= 40'h00_0000_0000;
      arlen_o   <= 4'h0;
      arsize_o  <= 3'h0;
      rready_o  <= 1'b0;
      rbeat     <= 4'h0;
    end else begin
      case (rd_state)
        RD_IDLE: begin
          rready_o <= 1'b0;
          // wait for pacing high, checked again only after all data back
          if (active && !zero_source_fill_mode && len != 32'h0 && wr_state == WR_IDLE
              && fcount == 5'h00 && (!cs[`DMAB_CS_PACE] || pace_s[1])) begin
            arvalid_o <= 1'b1;
            araddr_o  <= eff_addr(hi[7:0], src_lo);
            arlen_o   <= next_blen[3:0] - 4'h1;
            arsize_o  <= narrow ? 3'h2 : 3'h4;
            rbeat     <= 4'h0;
            rd_state  <= RD_ADDR;
          end
        end
        RD_ADDR: begin
          if (arready_i) begin
            arvalid_o <= 1'b0;
            rready_o  <= discard_destination_mode || free_next != 5'h00;
            rd_state  <= RD_DATA;
          end
        end
        default: begin
          // beats keep being taken even once active has dropped
          if (r_hs)
            rbeat <= rbeat + 4'h1;
          if (r_hs && (rlast_i || rbeat == arlen_o)) begin
            rready_o <= 1'b0;
            rd_state <= RD_IDLE;
          end else begin
            rready_o <= discard_destination_mode || free_next != 5'h00;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // write state machine: zero fill bursts or draining the buffer
  reg [4:0] wlen;
  always @* begin
    if (zero_source_fill_mode)
      wlen = next_blen;
    else if (IS_FAST)
      wlen = (fcount > `DMAB_MAX_BURST) ? `DMAB_MAX_BURST : fcount;
    else if (!narrow && !cs[`DMAB_CS_NOPAIR] && fcount >= 5'h02)
      wlen = 5'h02;
    else
      wlen = 5'h01;
  end
  wire wr_go = zero_source_fill_mode ? (active && len != 32'h0)
               : (fcount != 5'h00 && (!discard_destination_mode));

  always @(posedge clock_i) begin
    if (srst_i) begin
      wr_state  <= WR_IDLE;
      awvalid_o <= 1'b0;
      awaddr_o  <= 40'h00_0000_0000;
      awlen_o   <= 4'h0;
      awsize_o  <= 3'h0;
      wvalid_o  <= 1'b0;
      wdata_o   <= 128'h0;
      wstrb_o   <= 16'h0000;
      wlast_o   <= 1'b0;
      bready_o  <= 1'b0;
      wbeat     <= 4'h0;
    end else begin
      case (wr_state)
        WR_IDLE: begin
          if (wr_go && rd_state != RD_ADDR) begin
            awvalid_o <= 1'b1;
            awaddr_o  <= eff_addr(hi[15:8], dst_lo);
            awlen_o   <= wlen[3:0] - 4'h1;
            awsize_o  <= narrow ? 3'h2 : 3'h4;
            wr_state  <= WR_ADDR;
          end
        end
        WR_ADDR: begin
          if (awready_i) begin
            awvalid_o <= 1'b0;
            wvalid_o  <= 1'b1;
            wbeat     <= 4'h0;
            wlast_o   <= awlen_o == 4'h0;
            // zero data and zero strobes in fill mode
            wdata_o   <= zero_source_fill_mode ? 128'h0 : fhead;
            wstrb_o   <= zero_source_fill_mode ? 16'h0000 : 16'hFFFF;
            wr_state  <= WR_DATA;
          end
        end
        WR_DATA: begin
          if (w_hs) begin
            wbeat   <= wbeat + 4'h1;
            wlast_o <= (wbeat + 4'h1) == awlen_o;
            if (!zero_source_fill_mode)
              wdata_o <= fhead;
            if (wlast_o) begin
              wvalid_o <= 1'b0;
              bready_o <= 1'b1;
              wr_state <= WR_RESP;
            end
          end
        end
        default: begin
          if (bvalid_i) begin
            bready_o <= 1'b0;
            wr_state <= WR_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // apb slave: one wait state, then answer
  wire mapped = paddr_i == `DMAB_OFF_CS || paddr_i == `DMAB_OFF_SRC
                || paddr_i == `DMAB_OFF_DST || paddr_i == `DMAB_OFF_LEN
                || paddr_i == `DMAB_OFF_STRIDE || paddr_i == `DMAB_OFF_ROWS
                || paddr_i == `DMAB_OFF_NEXT || paddr_i == `DMAB_OFF_DEBUG
                || paddr_i == `DMAB_OFF_HI;
  wire err_sum = |dbg;
  reg [31:0] rd_word;
  always @* begin
    if (paddr_i == `DMAB_OFF_CS)
      rd_word = {15'h0, (rd_state != RD_IDLE || wr_state != WR_IDLE),
                 cs[15:4], err_sum, cs[2:0]};
    else if (paddr_i == `DMAB_OFF_SRC)
      rd_word = src_lo;
    else if (paddr_i == `DMAB_OFF_DST)
      rd_word = dst_lo;
    else if (paddr_i == `DMAB_OFF_LEN)
      rd_word = len;
    else if (paddr_i == `DMAB_OFF_STRIDE)
      rd_word = source_row_step;
    else if (paddr_i == `DMAB_OFF_ROWS)
      rd_word = row_count;
    else if (paddr_i == `DMAB_OFF_NEXT)
      rd_word = next_descriptor_pointer;
    else if (paddr_i == `DMAB_OFF_DEBUG)
      rd_word = {29'h0, dbg};
    else if (paddr_i == `DMAB_OFF_HI)
      rd_word = {16'h0, hi};
    else
      rd_word = 32'h0000_0000;
  end

  always @(posedge clock_i) begin
    if (srst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= psel_i && penable_i && !pready_o;
      pslverr_o <= psel_i && penable_i && !pready_o && !mapped;
      prdata_o  <= (psel_i && !pwrite_i) ? rd_word : 32'h0000_0000;
    end
  end

  // ==========================================================
  // register writes, hardware updates, sticky faults
  wire cs_wr  = apb_wr && paddr_i == `DMAB_OFF_CS;
  wire dbg_wr = apb_wr && paddr_i == `DMAB_OFF_DEBUG;
  wire [31:0] cs_in = IS_LITE ? (pwdata_i & ~32'h0000_0230) : pwdata_i;
  always @(posedge clock_i) begin
    if (srst_i) begin
      cs     <= `DMAB_RST_WORD;
      src_lo <= `DMAB_RST_WORD;
      dst_lo <= `DMAB_RST_WORD;
      len    <= `DMAB_RST_WORD;
      source_row_step         <= `DMAB_RST_WORD;
      row_count               <= `DMAB_RST_WORD;
      next_descriptor_pointer <= `DMAB_RST_WORD;
      hi     <= 16'h0000;
      dbg    <= 3'h0;
      irq_o  <= 1'b0;
    end else begin
      if (cs_wr) begin
        cs[31:3] <= {cs_in[31:4], 1'b0};
        cs[`DMAB_CS_ACTIVE] <= cs_in[`DMAB_CS_ACTIVE] && !cs_in[`DMAB_CS_ABORT];
        if (cs_in[`DMAB_CS_INTR])
          cs[`DMAB_CS_INTR] <= 1'b0;
        // abort with next pointer zero ends the transfer
        if (cs_in[`DMAB_CS_ABORT] && next_descriptor_pointer == 32'h0)
          len <= 32'h0;
      end
      if (apb_wr && paddr_i == `DMAB_OFF_SRC)
        src_lo <= pwdata_i;
      if (apb_wr && paddr_i == `DMAB_OFF_DST)
        dst_lo <= pwdata_i;
      if (apb_wr && paddr_i == `DMAB_OFF_LEN)
        len <= IS_LITE ? (pwdata_i & `DMAB_LITE_LEN_MASK) : pwdata_i;
      if (apb_wr && paddr_i == `DMAB_OFF_STRIDE && !IS_LITE)
        source_row_step <= pwdata_i;
      if (apb_wr && paddr_i == `DMAB_OFF_ROWS && !IS_LITE)
        row_count <= pwdata_i;
      if (apb_wr && paddr_i == `DMAB_OFF_NEXT)
        next_descriptor_pointer <= pwdata_i;
      if (apb_wr && paddr_i == `DMAB_OFF_HI)
        hi <= pwdata_i[15:0];
      // advance addresses and length per burst or zero-fill burst
      if (rd_state == RD_ADDR && arready_i) begin
        src_lo <= src_lo + ({28'h0, arlen_o} + 32'h1) * {27'h0, bbytes};
        len    <= len - ({28'h0, arlen_o} + 32'h1) * {27'h0, bbytes};
      end
      if (wr_state == WR_ADDR && awready_i) begin
        dst_lo <= dst_lo + ({28'h0, awlen_o} + 32'h1) * {27'h0, bbytes};
        if (zero_source_fill_mode)
          len <= len - ({28'h0, awlen_o} + 32'h1) * {27'h0, bbytes};
      end
      // finish: drop active, flag interrupt
      if (done) begin
        cs[`DMAB_CS_ACTIVE] <= 1'b0;
        cs[`DMAB_CS_INTR]   <= 1'b1;
      end
      // read fault drops active and flags interrupt; set beats clear
      if (rd_err) begin
        cs[`DMAB_CS_ACTIVE] <= 1'b0;
        cs[`DMAB_CS_INTR]   <= 1'b1;
      end
      // sticky faults: write one clears, a new event wins
      dbg <= (dbg & ~(dbg_wr ? pwdata_i[2:0] : 3'h0))
             | {rd_err, (HAS_EXT && ffault_s[1]), last_err};
      irq_o <= cs[`DMAB_CS_INTR];
    end
  end
endmodule // dmab_top

// File: tb.sv
// testbench: register, burst and fault scenarios for channel 0 of the burst engine
// assumes the partner model and the checker are compiled before it
`include "dmab_regs.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // stimulus and observed signals
  logic        clock_i = 0, srst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic        pacing_request_i = 0, fifo_fault_i = 0, drop_last_i = 0, slow_i = 0;
  logic [4:0]  err_beat_i = 5'h1f;  // faulted beat index, none by default
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0000_0000, q;
  logic        err_q;               // slave error of the last access
  wire  [31:0] prdata_o;
  wire         pready_o, pslverr_o, arvalid_o, arready_i, rvalid_i, rready_o, rlast_i;
  wire         awvalid_o, awready_i, wvalid_o, wready_i, wlast_o, bvalid_i, bready_o, irq_o;
  wire  [39:0] araddr_o, awaddr_o;
  wire  [3:0]  arlen_o, awlen_o;
  wire  [2:0]  arsize_o, awsize_o;
  wire [127:0] rdata_i, wdata_o;
  wire  [15:0] wstrb_o;
  wire  [1:0]  rresp_i;
  int          err_count = 0, compares = 0, cycles = 0;
  dmab_top #(.VARIANT(0), .CHANNEL(0)) u_dut (.*);
  dmab_axi_model u_axi (.*);
  initial forever #5 clock_i = ~clock_i;
  // hang guard
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      report_and_stop;
    end
  end
  task automatic report_and_stop;
    $display("compares=%0d errors=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // apb access with one held request until ready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel_i <= 1'b1; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    do @(posedge clock_i); while (pready_o !== 1'b1);
    q = prdata_o;
    err_q = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic do_reset;
    srst_i <= 1'b1; err_beat_i <= 5'h1f; drop_last_i <= 1'b0; slow_i <= 1'b0;
    pacing_request_i <= 1'b0; fifo_fault_i <= 1'b0;
    repeat (8) @(posedge clock_i);
    srst_i <= 1'b0;
  endtask
  task automatic start(input logic [31:0] len, input logic [31:0] cs);
    apb(1'b1, `DMAB_OFF_LEN, len);
    apb(1'b1, `DMAB_OFF_CS, cs);
  endtask
  // wide discard burst of sixteen beats, then settle
  task automatic disc_burst(input logic [31:0] len);
    start(len, 32'h0000_F021);
    wait (u_axi.rbeats == 16);
    repeat (6) @(posedge clock_i);
  endtask
  task automatic w1c(input logic [31:0] bits);
    apb(1'b1, `DMAB_OFF_DEBUG, bits);
    apb(1'b0, `DMAB_OFF_DEBUG, 0);
    `CHK(q[2:0], 3'h0)
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset;
    apb(1'b0, `DMAB_OFF_CS, 0); `CHK(q, 32'h0000_0000)
    apb(1'b0, `DMAB_OFF_DEBUG, 0); `CHK(q, 32'h0000_0000)
    apb(1'b1, 8'h40, 32'hFFFF_FFFF); `CHK(err_q, 1'b1)
    apb(1'b0, 8'h40, 0); `CHK({err_q, q}, 33'h1_0000_0000)
  endtask
  task automatic t_narrow;  // sixteen narrow beats fit with the extra fifo
    start(32'h0000_0040, 32'h0000_F041);
    @(posedge clock_i iff arvalid_o);
    `CHK({arlen_o, arsize_o}, 7'h7A)
  endtask
  task automatic t_discard;  // slow partner, nothing written
    slow_i <= 1'b1;
    start(32'h0000_0100, 32'h0000_F021);
    @(posedge clock_i iff arvalid_o);
    `CHK({arlen_o, arsize_o}, 7'h7C)
    wait (u_axi.rbeats == 16);
    repeat (8) @(posedge clock_i);
    `CHK(u_axi.awn, 0)
  endtask
  task automatic t_zfill;  // four zero beats, no reads
    start(32'h0000_0040, 32'h0000_3011);
    @(posedge clock_i iff awvalid_o);
    `CHK(awlen_o, 4'h3)
    wait (u_axi.bn == 1);
    `CHK(u_axi.wbeats, 4)
    `CHK(u_axi.wnz + u_axi.arn, 0)
  endtask
  task automatic t_rderr;  // fault on beat 2, rest of burst still taken
    err_beat_i <= 5'd2;
    disc_burst(32'h0000_0200);
    `CHK(irq_o, 1'b1)
    apb(1'b0, `DMAB_OFF_CS, 0); `CHK(q[3:0], 4'hA)
    apb(1'b0, `DMAB_OFF_DEBUG, 0); `CHK(q[2:0], 3'h4)
    w1c(32'h0000_0004);
    apb(1'b1, `DMAB_OFF_CS, 32'h0000_0004);
    apb(1'b0, `DMAB_OFF_LEN, 0); `CHK(q, 32'h0000_0000)
    apb(1'b0, `DMAB_OFF_CS, 0); `CHK(q[3], 1'b0)
  endtask
  task automatic t_nolast;
    drop_last_i <= 1'b1;
    disc_burst(32'h0000_0100);
    apb(1'b0, `DMAB_OFF_DEBUG, 0); `CHK(q[2:0], 3'h1)
    w1c(32'h0000_0001);
  endtask
  task automatic t_fifo;  // short fault pulse stays latched
    fifo_fault_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    fifo_fault_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    apb(1'b0, `DMAB_OFF_DEBUG, 0); `CHK(q[2:0], 3'h2)
    apb(1'b0, `DMAB_OFF_CS, 0); `CHK(q[3], 1'b1)
    w1c(32'h0000_0002);
  endtask
  task automatic t_pace;  // no read until pacing seen high
    start(32'h0000_0100, 32'h0000_F121);
    repeat (20) @(posedge clock_i);
    `CHK(u_axi.arn, 0)
    pacing_request_i <= 1'b1;
    wait (u_axi.rbeats == 16);
    repeat (6) @(posedge clock_i);
    `CHK(u_axi.arn, 1)
  endtask
  initial begin
    do_reset; t_reset;
    do_reset; t_narrow;
    do_reset; t_discard;
    do_reset; t_zfill;
    do_reset; t_rderr;
    do_reset; t_nolast;
    do_reset; t_fifo;
    do_reset; t_pace;
    report_and_stop;
  end
endmodule // tb
